// *** src/agomr_top.sv ***
// Gain, offset and first mode word register bank behind the serial port
`timescale 1ns/1ps
`default_nettype none
`include "agomr_cfg.svh"

// Contract
// - Gain code zero is lowest gain, all ones highest, span per range.
// - Gain field is bits 9 to 1, plain binary; bit 0 ignored.
// - Three offset words, red green blue, each coarse plus fine field.
// - Top two offset bits give coarse offset in 100mV steps, 00 zero.
// - Low eight offset bits give fine offset, 1.4mV steps, reset zero.
// - Positive correction acts against the usual imager offset direction.
// - Three-bit channel select picks one of eight input arrangements.
// - Channels unused by the selected arrangement are powered down.
// - Range bit clear gives 1x to 5x, set gives 1.5x to 7.5x.
// - Line clamp enable gates the external clamp timing input.
// - Sensor bit clear selects CCD, set selects CIS.
// - Width bit clear gives byte output, set nibble; nibble at reset.
// - Three-bit clamp field sets reference level on common negative input.
module agomr_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // Serial configuration port
    input wire logic SLOAD_N,
    input wire logic SCLK,
    input wire logic SDATA_I,
    output logic SDATA_O,
    output logic SDATA_OE_N,
    // External clamp timing
    input wire logic LINE_CLAMP_TIMING_IN,
    // Per-channel settings, index 0 red, 1 green, 2 blue
    output agomr_pkg::agomr_chan_out_s [2:0] CHAN_OUT,
    output logic [2:0] CHAN_POWER_DOWN,
    // Mode settings
    output agomr_pkg::agomr_mode_s MODE_OUT,
    output logic [1:0] FIRST_CHANNEL,
    output logic [1:0] SECOND_CHANNEL,
    output logic [1:0] ACTIVE_COUNT,
    output logic LINE_CLAMP_GATE,
    output logic CLAMP_REF_HIZ
);
    import agomr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] chan_active(input agomr_mux_e m);
        unique case (m)
            AGOMR_MUX_RGB: return 3'h7;
            AGOMR_MUX_R: return 3'h1;
            AGOMR_MUX_G: return 3'h2;
            AGOMR_MUX_B: return 3'h4;
            AGOMR_MUX_RG, AGOMR_MUX_GR: return 3'h3;
            AGOMR_MUX_GB: return 3'h6;
            AGOMR_MUX_BR: return 3'h5;
        endcase
    endfunction

    // First channel, second channel, count of channels in use
    function automatic logic [5:0] chan_order(input agomr_mux_e m);
        unique case (m)
            AGOMR_MUX_RGB: return {2'h0, 2'h1, 2'h3};
            AGOMR_MUX_R: return {2'h0, 2'h0, 2'h1};
            AGOMR_MUX_G: return {2'h1, 2'h1, 2'h1};
            AGOMR_MUX_B: return {2'h2, 2'h2, 2'h1};
            AGOMR_MUX_RG: return {2'h0, 2'h1, 2'h2};
            AGOMR_MUX_GR: return {2'h1, 2'h0, 2'h2};
            AGOMR_MUX_GB: return {2'h1, 2'h2, 2'h2};
            AGOMR_MUX_BR: return {2'h2, 2'h0, 2'h2};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sload_n_s;
    logic sclk_s;
    logic sdata_s;
    logic lclamp_s;

    agomr_pin_sync #(
        .W(4),
        .RST_VAL(4'h8)
    ) u_sync (
        .CLOCK(CLOCK),
        .RSTN(RSTN),
        .async_in({SLOAD_N, SCLK, SDATA_I, LINE_CLAMP_TIMING_IN}),
        .sync_out({sload_n_s, sclk_s, sdata_s, lclamp_s})
    );

    // ------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------
    agomr_ser_e state_q;
    logic sclk_prev_q;
    logic [4:0] bit_cnt_q;
    logic [`AGOMR_FRAME_BITS-1:0] in_sh_q;
    logic sclk_rise;
    logic commit;
    logic [`AGOMR_ADDR_W-1:0] wr_addr;
    logic [`AGOMR_WORD_W-1:0] wr_data;
    logic rd_frame_q;

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    // Read frames never write; short or long frames are dropped
    assign commit = (state_q == AGOMR_SER_END) && !rd_frame_q &&
                    (bit_cnt_q == 5'(`AGOMR_FRAME_BITS));
    assign wr_addr = in_sh_q[`AGOMR_FRAME_BITS-1:`AGOMR_WORD_W];
    assign wr_data = in_sh_q[`AGOMR_WORD_W-1:0];

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_q <= AGOMR_SER_IDLE;
        end
        else
        begin
            unique case (state_q)
                AGOMR_SER_IDLE:
                    if (!sload_n_s)
                        state_q <= AGOMR_SER_SHIFT;
                AGOMR_SER_SHIFT:
                    if (sload_n_s)
                        state_q <= AGOMR_SER_END;
                AGOMR_SER_END:
                    state_q <= AGOMR_SER_IDLE;
                default:
                    state_q <= AGOMR_SER_IDLE;
            endcase
        end
    end

    // Count saturates one past a full frame so long frames stay dropped
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            bit_cnt_q <= '0;
            in_sh_q <= '0;
        end
        else if (state_q == AGOMR_SER_IDLE)
        begin
            bit_cnt_q <= '0;
        end
        else if (state_q == AGOMR_SER_SHIFT && sclk_rise)
        begin
            in_sh_q <= {in_sh_q[`AGOMR_FRAME_BITS-2:0], sdata_s};
            if (bit_cnt_q <= 5'(`AGOMR_FRAME_BITS))
                bit_cnt_q <= bit_cnt_q + 5'h1;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [`AGOMR_WORD_W-1:0] gain_q [3];
    logic [`AGOMR_WORD_W-1:0] ofs_q [3];
    logic [`AGOMR_WORD_W-1:0] mode1_q;
    logic soft_rst;
    logic rd_req;

    assign soft_rst = commit && wr_addr == `AGOMR_ADDR_CTRL &&
                      wr_data[`AGOMR_CTRL_RESET_BIT];
    assign rd_req = commit && wr_addr == `AGOMR_ADDR_CTRL &&
                    wr_data[`AGOMR_CTRL_READ_BIT];

    // Whole word kept, so bit 0 reads back but never reaches gain
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int i = 0; i < 3; i++)
                gain_q[i] <= `AGOMR_GAIN_RST;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                if (soft_rst)
                    gain_q[i] <= `AGOMR_GAIN_RST;
                else if (commit && wr_addr == `AGOMR_ADDR_GAIN_R + 4'(i))
                    gain_q[i] <= wr_data;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int i = 0; i < 3; i++)
                ofs_q[i] <= `AGOMR_OFS_RST;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                if (soft_rst)
                    ofs_q[i] <= `AGOMR_OFS_RST;
                else if (commit && wr_addr == `AGOMR_ADDR_OFS_R + 4'(i))
                    ofs_q[i] <= wr_data;
        end
    end

    // Reset value has nibble output and all else clear
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
            mode1_q <= `AGOMR_MODE1_RST;
        else if (soft_rst)
            mode1_q <= `AGOMR_MODE1_RST;
        else if (commit && wr_addr == `AGOMR_ADDR_MODE1)
            mode1_q <= wr_data;
    end

    // ------------------------------------------------------------
    // Readback: request frame, then the next frame shifts the word out
    // ------------------------------------------------------------
    logic rd_pend_q;
    logic [`AGOMR_ADDR_W-1:0] rd_sel_q;
    logic [`AGOMR_WORD_W-1:0] out_sh_q;
    logic [`AGOMR_WORD_W-1:0] rd_word;

    always_comb
    begin
        rd_word = '0;
        if (rd_sel_q <= `AGOMR_ADDR_GAIN_B)
            rd_word = gain_q[2'(rd_sel_q)];
        else if (rd_sel_q <= `AGOMR_ADDR_OFS_B)
            rd_word = ofs_q[2'(rd_sel_q - `AGOMR_ADDR_OFS_R)];
        else if (rd_sel_q == `AGOMR_ADDR_MODE1)
            rd_word = mode1_q;
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rd_pend_q <= 1'b0;
            rd_sel_q <= '0;
        end
        else if (rd_req)
        begin
            rd_pend_q <= 1'b1;
            rd_sel_q <= wr_data[`AGOMR_CTRL_SEL_MSB:0];
        end
        else if (soft_rst || (state_q == AGOMR_SER_END && rd_frame_q))
        begin
            rd_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rd_frame_q <= 1'b0;
            out_sh_q <= '0;
        end
        else if (state_q == AGOMR_SER_IDLE && !sload_n_s)
        begin
            rd_frame_q <= rd_pend_q;
            out_sh_q <= rd_word;
        end
        else if (state_q == AGOMR_SER_SHIFT && sclk_rise)
        begin
            out_sh_q <= {out_sh_q[`AGOMR_WORD_W-2:0], 1'b0};
        end
        else if (state_q == AGOMR_SER_END)
        begin
            rd_frame_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            SDATA_O <= 1'b0;
            SDATA_OE_N <= 1'b1;
        end
        else
        begin
            SDATA_O <= out_sh_q[`AGOMR_WORD_W-1];
            SDATA_OE_N <= !(rd_frame_q && state_q == AGOMR_SER_SHIFT);
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    agomr_mode_s mode;
    logic [2:0] active;

    assign mode = agomr_mode_s'(mode1_q);
    assign active = chan_active(mode.input_mux_select);

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            MODE_OUT <= agomr_mode_s'(`AGOMR_MODE1_RST);
            CHAN_POWER_DOWN <= 3'h0;
            {FIRST_CHANNEL, SECOND_CHANNEL, ACTIVE_COUNT} <= 6'h07;
            CLAMP_REF_HIZ <= 1'b1;
        end
        else
        begin
            MODE_OUT <= mode;
            CHAN_POWER_DOWN <= ~active;
            {FIRST_CHANNEL, SECOND_CHANNEL, ACTIVE_COUNT} <=
                chan_order(mode.input_mux_select);
            // Lets the system drive its own reference
            CLAMP_REF_HIZ <= mode.clamp_ref == AGOMR_CREF_HIZ;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
            LINE_CLAMP_GATE <= 1'b0;
        else
            LINE_CLAMP_GATE <= mode.line_clamp_enable & lclamp_s;
    end

    // ------------------------------------------------------------
    // Channel decoders
    // ------------------------------------------------------------
    for (genvar c = 0; c < 3; c++)
    begin : g_chan
        agomr_chan_cfg_s cfg;
        assign cfg.gain_code = gain_q[c][`AGOMR_GAIN_MSB:`AGOMR_GAIN_LSB];
        assign cfg.gain_range_select = mode.gain_range_select;
        assign cfg.coarse_offset_field =
            ofs_q[c][`AGOMR_COARSE_MSB:`AGOMR_COARSE_LSB];
        assign cfg.fine_offset_field =
            ofs_q[c][`AGOMR_FINE_MSB:`AGOMR_FINE_LSB];

        agomr_chan_decode u_dec (
            .CLOCK(CLOCK),
            .RSTN(RSTN),
            .cfg(cfg),
            .active(active[c]),
            .dec(CHAN_OUT[c])
        );
    end

endmodule // agomr_top

`default_nettype wire

// *** src/agomr_cfg.svh ***
// Offsets, field positions, reset values and scale figures of the bank
`ifndef AGOMR_CFG_SVH
`define AGOMR_CFG_SVH

// Word and frame sizes
`define AGOMR_ADDR_W 4
`define AGOMR_WORD_W 10
`define AGOMR_FRAME_BITS 14

// Register addresses
`define AGOMR_ADDR_GAIN_R 4'h0
`define AGOMR_ADDR_GAIN_G 4'h1
`define AGOMR_ADDR_GAIN_B 4'h2
`define AGOMR_ADDR_OFS_R 4'h3
`define AGOMR_ADDR_OFS_G 4'h4
`define AGOMR_ADDR_OFS_B 4'h5
`define AGOMR_ADDR_MODE1 4'h6
`define AGOMR_ADDR_CTRL 4'hf

// Field positions
`define AGOMR_GAIN_MSB 9
`define AGOMR_GAIN_LSB 1
`define AGOMR_COARSE_MSB 9
`define AGOMR_COARSE_LSB 8
`define AGOMR_FINE_MSB 7
`define AGOMR_FINE_LSB 0
`define AGOMR_CTRL_RESET_BIT 9
`define AGOMR_CTRL_READ_BIT 8
`define AGOMR_CTRL_SEL_MSB 3

// Power-on values
`define AGOMR_GAIN_RST 10'h000
`define AGOMR_OFS_RST 10'h000
`define AGOMR_MODE1_RST 10'h008

// Gain spans in thousandths, full-scale code
`define AGOMR_GAIN_BASE_LO 1000
`define AGOMR_GAIN_TOP_LO 5000
`define AGOMR_GAIN_BASE_HI 1500
`define AGOMR_GAIN_TOP_HI 7500
`define AGOMR_GAIN_FULL 511

// Offset steps: coarse in mV, fine in tenths of a mV
`define AGOMR_COARSE_STEP 100
`define AGOMR_FINE_STEP 14

`endif

// *** src/agomr_pkg.sv ***
// Types shared by the gain, offset and mode register bank
package agomr_pkg;

    typedef enum logic [2:0] {
        AGOMR_MUX_RGB = 3'h0,
        AGOMR_MUX_R = 3'h1,
        AGOMR_MUX_G = 3'h2,
        AGOMR_MUX_B = 3'h3,
        AGOMR_MUX_RG = 3'h4,
        AGOMR_MUX_GR = 3'h5,
        AGOMR_MUX_GB = 3'h6,
        AGOMR_MUX_BR = 3'h7
    } agomr_mux_e;

    typedef enum logic [2:0] {
        AGOMR_CREF_HIZ = 3'h0,
        AGOMR_CREF_0V0 = 3'h1,
        AGOMR_CREF_1V25 = 3'h2,
        AGOMR_CREF_2V0 = 3'h3,
        AGOMR_CREF_2V6 = 3'h4,
        AGOMR_CREF_2V8 = 3'h5,
        AGOMR_CREF_3V0 = 3'h6,
        AGOMR_CREF_VDD = 3'h7
    } agomr_cref_e;

    typedef enum logic [1:0] {
        AGOMR_SER_IDLE = 2'h0,
        AGOMR_SER_SHIFT = 2'h1,
        AGOMR_SER_END = 2'h3
    } agomr_ser_e;

    // Same bit order as the first mode word
    typedef struct packed {
        agomr_mux_e input_mux_select;
        logic gain_range_select;
        logic line_clamp_enable;
        logic sensor_type_select;
        logic nibble_out;
        agomr_cref_e clamp_ref;
    } agomr_mode_s;

    typedef struct packed {
        logic [8:0] gain_code;
        logic gain_range_select;
        logic [1:0] coarse_offset_field;
        logic [7:0] fine_offset_field;
    } agomr_chan_cfg_s;

    typedef struct packed {
        logic powered;
        logic [8:0] gain_code;
        logic [12:0] gain_milli;
        logic signed [8:0] coarse_mv;
        logic signed [11:0] fine_tenth_mv;
    } agomr_chan_out_s;

endpackage

// *** src/agomr_pin_sync.sv ***
// Two-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module agomr_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // agomr_pin_sync

`default_nettype wire

// *** src/agomr_chan_decode.sv ***
// Per-channel decode of gain and offset words into scaled settings
`timescale 1ns/1ps
`default_nettype none
`include "agomr_cfg.svh"

module agomr_chan_decode (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // Raw settings
    input wire agomr_pkg::agomr_chan_cfg_s cfg,
    input wire logic active,
    // Decoded settings
    output agomr_pkg::agomr_chan_out_s dec
);
    import agomr_pkg::*;

    // Linear from base at code 0 to top at all-ones
    function automatic logic [12:0] gain_milli(input logic [8:0] code,
                                              input logic hi);
        logic [22:0] prod;
        logic [12:0] base;
        logic [12:0] span;
        base = hi ? 13'(`AGOMR_GAIN_BASE_HI) : 13'(`AGOMR_GAIN_BASE_LO);
        span = hi ? 13'(`AGOMR_GAIN_TOP_HI - `AGOMR_GAIN_BASE_HI)
                  : 13'(`AGOMR_GAIN_TOP_LO - `AGOMR_GAIN_BASE_LO);
        prod = 23'(code) * 23'(span);
        return base + 13'(prod / 23'(`AGOMR_GAIN_FULL));
    endfunction

    function automatic logic signed [8:0] coarse_mv(input logic [1:0] c);
        unique case (c)
            2'h0: return 9'sd0;
            2'h1: return -9'(`AGOMR_COARSE_STEP);
            2'h2: return 9'(`AGOMR_COARSE_STEP);
            2'h3: return 9'(2 * `AGOMR_COARSE_STEP);
        endcase
    endfunction

    // Sign and magnitude: both zero codes give no offset
    function automatic logic signed [11:0] fine_tmv(input logic [7:0] f);
        logic [11:0] mag;
        mag = 12'(f[6:0]) * 12'(`AGOMR_FINE_STEP);
        return f[7] ? -$signed(mag) : $signed(mag);
    endfunction

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            dec <= '0;
        end
        else
        begin
            dec.powered <= active;
            dec.gain_code <= cfg.gain_code;
            dec.gain_milli <= gain_milli(cfg.gain_code,
                                         cfg.gain_range_select);
            // Positive values oppose the usual imager offset
            dec.coarse_mv <= coarse_mv(cfg.coarse_offset_field);
            dec.fine_tenth_mv <= fine_tmv(cfg.fine_offset_field);
        end
    end

endmodule // agomr_chan_decode

`default_nettype wire

// *** testbench/agomr_monitor.sv ***
// Checker of the register bank's decoded outputs
`timescale 1ns/1ps
`default_nettype none

module agomr_monitor (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // Watched pins
    input wire logic LINE_CLAMP_TIMING_IN,
    input wire agomr_pkg::agomr_chan_out_s [2:0] CHAN_OUT,
    input wire logic [2:0] CHAN_POWER_DOWN,
    input wire agomr_pkg::agomr_mode_s MODE_OUT,
    input wire logic [1:0] FIRST_CHANNEL,
    input wire logic [1:0] SECOND_CHANNEL,
    input wire logic [1:0] ACTIVE_COUNT,
    input wire logic LINE_CLAMP_GATE,
    input wire logic CLAMP_REF_HIZ
);
    import agomr_pkg::*;

    localparam logic [2:0] PD_T [8] = '{3'h0, 3'h6, 3'h5, 3'h3,
                                        3'h4, 3'h4, 3'h1, 3'h2};
    localparam logic [5:0] ORD_T [8] = '{6'h07, 6'h01, 6'h15, 6'h29,
                                         6'h06, 6'h12, 6'h1a, 6'h22};

    function automatic logic [12:0] milli(input logic [8:0] c,
                                          input logic r);
        return r ? 13'(1500 + c * 6000 / 511) : 13'(1000 + c * 4000 / 511);
    endfunction

    function automatic logic gain_ok(input agomr_chan_out_s c,
                                     input logic r);
        return c.gain_milli == milli(c.gain_code, r);
    endfunction

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    property p_hiz;
        $stable(MODE_OUT) [*3] |->
            CLAMP_REF_HIZ == (MODE_OUT.clamp_ref == AGOMR_CREF_HIZ);
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("clamp hi-z flag disagrees with clamp field");

    property p_pd;
        $stable(MODE_OUT) [*3] |->
            CHAN_POWER_DOWN == PD_T[MODE_OUT.input_mux_select];
    endproperty
    a_pd: assert property (p_pd)
        else $error("wrong channels powered down");

    property p_order;
        $stable(MODE_OUT) [*3] |-> {FIRST_CHANNEL, SECOND_CHANNEL,
            ACTIVE_COUNT} == ORD_T[MODE_OUT.input_mux_select];
    endproperty
    a_order: assert property (p_order)
        else $error("channel order or count wrong");

    property p_power;
        $stable(CHAN_POWER_DOWN) [*3] |-> {CHAN_OUT[2].powered,
            CHAN_OUT[1].powered, CHAN_OUT[0].powered} == ~CHAN_POWER_DOWN;
    endproperty
    a_power: assert property (p_power)
        else $error("powered flag disagrees with power down");

    property p_gain;
        $stable(MODE_OUT) [*4] |->
            gain_ok(CHAN_OUT[0], MODE_OUT.gain_range_select) &&
            gain_ok(CHAN_OUT[1], MODE_OUT.gain_range_select) &&
            gain_ok(CHAN_OUT[2], MODE_OUT.gain_range_select);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain value does not follow code and range");

    property p_coarse;
        CHAN_OUT[1].coarse_mv inside {9'sd0, -9'sd100, 9'sd100, 9'sd200};
    endproperty
    a_coarse: assert property (p_coarse)
        else $error("coarse offset off the 100mV grid");

    property p_fine;
        CHAN_OUT[2].fine_tenth_mv % 14 == 0 &&
            CHAN_OUT[2].fine_tenth_mv <= 1778 &&
            CHAN_OUT[2].fine_tenth_mv >= -1778;
    endproperty
    a_fine: assert property (p_fine)
        else $error("fine offset off its step or span");

    property p_clamp_off;
        !MODE_OUT.line_clamp_enable [*4] |-> !LINE_CLAMP_GATE;
    endproperty
    a_clamp_off: assert property (p_clamp_off)
        else $error("clamp gate open while disabled");

    property p_clamp_on;
        (LINE_CLAMP_TIMING_IN && MODE_OUT.line_clamp_enable) [*5]
            |-> LINE_CLAMP_GATE;
    endproperty
    a_clamp_on: assert property (p_clamp_on)
        else $error("clamp gate closed while enabled and timed");
endmodule // agomr_monitor

bind agomr_top agomr_monitor u_mon (.CLOCK(CLOCK), .RSTN(RSTN),
    .LINE_CLAMP_TIMING_IN(LINE_CLAMP_TIMING_IN), .CHAN_OUT(CHAN_OUT),
    .CHAN_POWER_DOWN(CHAN_POWER_DOWN), .MODE_OUT(MODE_OUT),
    .FIRST_CHANNEL(FIRST_CHANNEL), .SECOND_CHANNEL(SECOND_CHANNEL),
    .ACTIVE_COUNT(ACTIVE_COUNT), .LINE_CLAMP_GATE(LINE_CLAMP_GATE),
    .CLAMP_REF_HIZ(CLAMP_REF_HIZ));

`default_nettype wire

// *** testbench/agomr_host_model.sv ***
// Host controller model driving the three-pin serial configuration port
`timescale 1ns/1ps
`default_nettype none

module agomr_host_model (
    // Clock
    input wire logic CLOCK,
    // Serial port
    output logic SLOAD_N,
    output logic SCLK,
    output logic SDATA_I,
    input wire logic SDATA_O
);
    initial
    begin
        SLOAD_N = 1'b1;
        SCLK = 1'b0;
        SDATA_I = 1'b0;
    end

    // Sends nbits of w MSB first, samples the device before each rise
    task automatic frame(input int nbits, input logic [13:0] w,
                         output logic [13:0] r);
        r = '0;
        SLOAD_N <= 1'b0;
        repeat (5) @(negedge CLOCK);
        for (int i = 0; i < nbits; i++)
        begin
            SDATA_I <= w[13 - i];
            repeat (4) @(negedge CLOCK);
            r = {r[12:0], SDATA_O};
            SCLK <= 1'b1;
            repeat (4) @(negedge CLOCK);
            SCLK <= 1'b0;
        end
        repeat (4) @(negedge CLOCK);
        SLOAD_N <= 1'b1;
        // Released line flips so a stale bit is never mistaken for data
        SDATA_I <= ~SDATA_I;
        repeat (6) @(negedge CLOCK);
    endtask
endmodule // agomr_host_model

`default_nettype wire

// *** testbench/afe_gain_offset_mode_regs_tb.sv ***
// Self-checking bench for the gain, offset and first mode register bank
`timescale 1ns/1ps
`default_nettype none

module afe_gain_offset_mode_regs_tb;
    import agomr_pkg::*;

    logic clock, rstn, sload_n, sclk, sdata_i, sdata_o, sdata_oe_n;
    logic lclamp_in, lclamp_gate, cref_hiz;
    agomr_chan_out_s [2:0] chan_out;
    agomr_mode_s mode_out;
    logic [2:0] chan_pd;
    logic [1:0] first_chan, second_chan, act_count;
    logic [3:0] rb;
    logic [13:0] junk;
    int gain_m[3], ofs_m[3], mode_m, errors, cmp_count, cycles;
    int pd_t[8] = '{0, 6, 5, 3, 4, 4, 1, 2};
    int ord_t[8] = '{7, 1, 21, 41, 6, 18, 26, 34};
    int coarse_t[4] = '{0, -100, 100, 200};

    agomr_top dut (.CLOCK(clock), .RSTN(rstn), .SLOAD_N(sload_n),
        .SCLK(sclk), .SDATA_I(sdata_i), .SDATA_O(sdata_o),
        .SDATA_OE_N(sdata_oe_n), .LINE_CLAMP_TIMING_IN(lclamp_in),
        .CHAN_OUT(chan_out), .CHAN_POWER_DOWN(chan_pd),
        .MODE_OUT(mode_out), .FIRST_CHANNEL(first_chan),
        .SECOND_CHANNEL(second_chan), .ACTIVE_COUNT(act_count),
        .LINE_CLAMP_GATE(lclamp_gate), .CLAMP_REF_HIZ(cref_hiz));

    agomr_host_model host (.CLOCK(clock), .SLOAD_N(sload_n), .SCLK(sclk),
        .SDATA_I(sdata_i), .SDATA_O(sdata_o));

    always #2.5 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic reset_model();
        gain_m = '{0, 0, 0};
        ofs_m = '{0, 0, 0};
        mode_m = 8;
    endtask

    // ----------------------------------------------------------------
    // Compare every decoded output
    // ----------------------------------------------------------------
    task automatic check_all();
        int m, f, g;
        m = mode_m >> 7;
        repeat (10) @(negedge clock);
        check("mode", 32'(mode_out), mode_m);
        check("power down", 32'(chan_pd), pd_t[m]);
        check("order", 32'({first_chan, second_chan, act_count}), ord_t[m]);
        check("clamp gate", 32'(lclamp_gate), lclamp_in & mode_m[5]);
        check("hi-z", 32'(cref_hiz), (mode_m & 7) == 0);
        for (int c = 0; c < 3; c++)
        begin
            g = gain_m[c] >> 1;
            f = ofs_m[c] & 255;
            check("powered", 32'(chan_out[c].powered), !pd_t[m][c]);
            check("gain code", 32'(chan_out[c].gain_code), g);
            check("gain", 32'(chan_out[c].gain_milli), mode_m[6] ?
                1500 + g * 6000 / 511 : 1000 + g * 4000 / 511);
            check("coarse", 32'($signed(chan_out[c].coarse_mv)),
                coarse_t[ofs_m[c] >> 8]);
            check("fine", 32'($signed(chan_out[c].fine_tenth_mv)),
                (f[7] ? -14 : 14) * (f & 127));
        end
    endtask

    task automatic rd(input logic [3:0] a);
        logic [13:0] r;
        host.frame(14, {4'hf, 2'b01, 4'h0, a}, r);
        host.frame(14, 14'h0, r);
        check("readback", 32'(r[13:4]), a <= 4'h2 ? gain_m[a] :
            a <= 4'h5 ? ofs_m[a - 4'h3] : a == 4'h6 ? mode_m : 0);
    endtask

    task automatic wr(input logic [3:0] a, input logic [9:0] d);
        host.frame(14, {a, d}, junk);
        if (a <= 4'h2)
            gain_m[a] = d;
        else if (a <= 4'h5)
            ofs_m[a - 4'h3] = d;
        else if (a == 4'h6)
            mode_m = d;
        else if (a == 4'hf && d[9])
            reset_model();
        if (a != 4'hf)
            rd(a);
        check_all();
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        rstn = 1'b0;
        lclamp_in = 1'b0;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        reset_model();
        void'($urandom(32'h1b103698));
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        check_all();
        for (int a = 0; a < 15; a++)
            rd(4'(a));
        $display("test power_on done");
        for (int s = 0; s < 2; s++)
        begin
            wr(4'h6, s ? 10'h048 : 10'h008);
            wr(4'h0, 10'h001);
            wr(4'h1, 10'h3ff);
            wr(4'h2, 10'($urandom) | 10'h001);
        end
        $display("test gain done");
        for (int k = 0; k < 4; k++)
            wr(4'(3 + k % 3), {2'(k), 8'($urandom)});
        wr(4'h4, 10'h07f);
        wr(4'h5, 10'h2ff);
        $display("test offset done");
        for (int i = 0; i < 8; i++)
        begin
            rb = 4'($urandom);
            lclamp_in = rb[3];
            // CIS only with low reference codes; 000 frees the input
            wr(4'h6, {3'(i), rb[0], rb[1], 3'(7 - i) < 3'h3, rb[2],
                3'(7 - i)});
        end
        lclamp_in = 1'b1;
        wr(4'h6, 10'h028);
        lclamp_in = 1'b0;
        check_all();
        $display("test mode done");
        host.frame(13, {4'h0, 10'h2aa}, junk);
        check_all();
        wr(4'h9, 10'h3ff);
        wr(4'hf, 10'h200);
        rd(4'h6);
        $display("test refusal done");
        complete_run();
    end
endmodule // afe_gain_offset_mode_regs_tb

`default_nettype wire
